// [exec_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module exec_checker (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic instr_valid_in,
	input wire logic [13:0] instr_in,
	input wire logic [7:0] reg_rdata_in,
	input wire exec_pkg::reg_write_t reg_write_out,
	input wire logic [7:0] acc_out,
	input wire exec_pkg::flags_t flags_out,
	input wire logic osc_halt_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);
	wire [7:0] d=reg_rdata_in;
	wire [4:0] f=flags_out;
	// 3f is no opcode, so idle and halted cycles match nothing
	wire [5:0] op=instr_valid_in&&!osc_halt_out?instr_in[13:8]:6'h3f;
	wire b=instr_in[7];
	rot_acc_a:
		assert property(op==6'h0d&&!b|=>acc_out=={$past(d[6:0]),$past(f[0])})else $error("rot");
	rot_flag_a:
		assert property(op==6'h0d|=>f=={$past(f[4:1]),$past(d[7])})else $error("rot flags");
	dest_sel_a:
		assert property(op==6'h0e|=>reg_write_out.en==$past(b))else $error("dest");
	addr_copy_a:
		assert property(op==6'h0e&&b|=>reg_write_out.addr==$past(instr_in[6:0]))else $error("addr");
	halt_entry_a:
		assert property(op==6'h00&&instr_in[7:0]==8'h03|=>osc_halt_out&&f[2:0]==$past(f[2:0]))
			else $error("sleep");
	sub_carry_a:
		assert property(op==6'h02|=>f[0]==($past(d)>=$past(acc_out)))else $error("sub");
	swap_acc_a:
		assert property(op==6'h0e&&!b|=>acc_out=={$past(d[3:0]),$past(d[7:4])}&&f==$past(f))
			else $error("swap");
	zero_test_a:
		assert property(op==6'h08&&b|=>f[2]==($past(d)==8'h00)&&!reg_write_out.en)else $error("zt");
	cover property(op==6'h02);
	cover property(op==6'h08&&b);
	cover property(osc_halt_out);
endmodule : exec_checker
bind rotate_sub_swap_test_sleep_exec exec_checker u_chk(.*);
`default_nettype wire

// [exec_map.svh]
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH
// 14-bit instruction word fields
`define OPC_HI 13
`define OPC_LO 8
`define DEST_BIT 7
`define ADDR_HI 6
`define ADDR_LO 0
`define OPC_ROTATE 6'h0d
`define OPC_SUBTRACT 6'h02
`define OPC_NIBBLE 6'h0e
`define OPC_ZTEST 6'h08
`define WORD_POWERDOWN 14'h0003
// reset values
`define ACC_RST 8'h00
`define FLAGS_RST 5'h18
// status bits written on power-down entry
`define PD_EXPIRY_VAL 1'b1
`define PD_POWERDOWN_VAL 1'b0
`endif

// [exec_pkg.sv]
package exec_pkg;
	typedef enum logic [4:0] {
		OP_NONE = 5'h01,
		OP_ROTATE = 5'h02,
		OP_SUBTRACT = 5'h04,
		OP_NIBBLE = 5'h08,
		OP_ZTEST = 5'h10
	} op_t;
	typedef struct packed {
		logic watchdog_expiry_flag;
		logic powerdown_flag;
		logic zero;
		logic nibble_borrow_flag;
		logic carry;
	} flags_t;
	typedef struct packed {
		logic en;
		logic [6:0] addr;
		logic [7:0] data;
	} reg_write_t;
endpackage : exec_pkg

// [rotate_sub_swap_test_sleep_exec.sv]
// Operation
// - rotate-left: reg shifts left, old carry to bit0, bit7 to carry only.
// - destination bit 0 writes accumulator, 1 writes the addressed register.
// - operand is 7-bit direct address in low bits, 00h to 7Fh.
// - power-down opcode halts oscillator, completes in one cycle.
// - power-down updates time-out and power-down bits, no other flag.
// - subtract computes register minus accumulator; updates carry, digit carry, zero.
// - carry 1 on no borrow incl. equal; zero only for zero result.
// - nibble exchange swaps high and low nibbles; no flags changed.
// - zero test sets zero flag on zero register; writes nothing else.
`include "exec_map.svh"
`timescale 1ns/100ps
`default_nettype none
module rotate_sub_swap_test_sleep_exec (
	// clock and reset
	input wire logic clock_in,
	input wire logic sys_rst_in,
	// fetched instruction, one per cycle while valid
	input wire logic instr_valid_in,
	input wire logic [13:0] instr_in,
	// register file read data for the operand address
	input wire logic [7:0] reg_rdata_in,
	// wake event from outside; restarts the oscillator
	input wire logic wake_in,
	// register file read address (combinational decode is not allowed on outputs)
	output logic [6:0] reg_raddr_out,
	// register file write
	output exec_pkg::reg_write_t reg_write_out,
	// accumulator and status
	output logic [7:0] acc_out,
	output exec_pkg::flags_t flags_out,
	// oscillator control and instruction done strobe
	output logic osc_halt_out,
	output logic done_out
);
	// wake is asynchronous to the core clock
	logic wake_s1_r;
	logic wake_s2_r;

	logic [7:0] acc_r;
	logic [7:0] acc_nxt;
	exec_pkg::flags_t flags_r;
	exec_pkg::flags_t flags_nxt;
	exec_pkg::reg_write_t wr_r;
	exec_pkg::reg_write_t wr_nxt;
	logic halt_r;
	logic halt_nxt;
	logic done_r;
	logic [6:0] raddr_r;

	// decode
	wire [5:0] opc = instr_in[`OPC_HI:`OPC_LO];
	wire dest_reg = instr_in[`DEST_BIT];
	wire [6:0] addr = instr_in[`ADDR_HI:`ADDR_LO];
	wire go = instr_valid_in && !halt_r;
	wire is_pd = go && (instr_in == `WORD_POWERDOWN);
	wire is_ztest = opc == `OPC_ZTEST && dest_reg;
	exec_pkg::op_t op;
	assign op = !go ? exec_pkg::OP_NONE :
		(opc == `OPC_ROTATE) ? exec_pkg::OP_ROTATE :
		(opc == `OPC_SUBTRACT) ? exec_pkg::OP_SUBTRACT :
		(opc == `OPC_NIBBLE) ? exec_pkg::OP_NIBBLE :
		is_ztest ? exec_pkg::OP_ZTEST : exec_pkg::OP_NONE;

	// operand is presented by the register file in the same cycle as the word
	wire [7:0] f = reg_rdata_in;

	// rotate through carry; carry is the only flag it touches
	wire [8:0] rot = {f, flags_r.carry};
	wire [7:0] rot_res = rot[7:0];
	wire rot_carry = rot[8];

	// two's complement: f + ~w + 1, carry out means no borrow
	wire [8:0] diff = {1'b0, f} + {1'b0, ~acc_r} + 9'h001;
	wire [4:0] ldiff = {1'b0, f[3:0]} + {1'b0, ~acc_r[3:0]} + 5'h01;
	wire [7:0] diff_res = diff[7:0];
	wire diff_no_borrow = diff[8];
	wire nib_no_borrow = ldiff[4];
	wire diff_zero = diff_res == 8'h00;

	// zero test looks at the operand alone, not at the adder
	wire f_zero = f == 8'h00;

	// nibble exchange as one lane per result bit
	logic [7:0] swp;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_swap
			assign swp[gi] = f[(gi + 4) % 8];
		end
	endgenerate

	// result and write strobe; the zero test never writes
	logic [7:0] res;
	logic writes;
	always_comb begin
		res = 8'h00;
		writes = 1'b0;
		case (op)
			exec_pkg::OP_ROTATE: begin
				res = rot_res;
				writes = 1'b1;
			end
			exec_pkg::OP_SUBTRACT: begin
				res = diff_res;
				writes = 1'b1;
			end
			exec_pkg::OP_NIBBLE: begin
				res = swp;
				writes = 1'b1;
			end
			exec_pkg::OP_ZTEST: begin
				res = 8'h00;
				writes = 1'b0;
			end
			exec_pkg::OP_NONE: begin
				res = 8'h00;
			end
			default: begin
				res = 8'h00;
			end
		endcase
	end

	// status flags; anything not named keeps its value
	always_comb begin
		flags_nxt = flags_r;
		case (op)
			exec_pkg::OP_ROTATE: begin
				flags_nxt.carry = rot_carry;
			end
			exec_pkg::OP_SUBTRACT: begin
				flags_nxt.carry = diff_no_borrow;
				flags_nxt.nibble_borrow_flag = nib_no_borrow;
				flags_nxt.zero = diff_zero;
			end
			exec_pkg::OP_NIBBLE: begin
				flags_nxt = flags_r;
			end
			exec_pkg::OP_ZTEST: begin
				flags_nxt.zero = f_zero;
			end
			exec_pkg::OP_NONE: begin
				flags_nxt = flags_r;
			end
			default: begin
				flags_nxt = flags_r;
			end
		endcase
		// power-down word decodes as no operation but still marks the status
		if (is_pd) begin
			flags_nxt.watchdog_expiry_flag = `PD_EXPIRY_VAL;
			flags_nxt.powerdown_flag = `PD_POWERDOWN_VAL;
		end
	end

	// destination select
	assign acc_nxt = (writes && !dest_reg) ? res : acc_r;
	assign wr_nxt = '{en: writes && dest_reg, addr: addr, data: res};
	assign halt_nxt = is_pd ? 1'b1 : (wake_s2_r ? 1'b0 : halt_r);

	always_ff @(posedge clock_in) begin
		wake_s1_r <= wake_in;
		wake_s2_r <= wake_s1_r;
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			acc_r <= `ACC_RST;
		end else begin
			acc_r <= acc_nxt;
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			flags_r <= `FLAGS_RST;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			wr_r <= '0;
		end else begin
			wr_r <= wr_nxt;
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			halt_r <= 1'b0;
		end else begin
			halt_r <= halt_nxt;
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			done_r <= 1'b0;
		end else begin
			done_r <= go;
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			raddr_r <= 7'h00;
		end else begin
			raddr_r <= addr;
		end
	end

	assign reg_raddr_out = raddr_r;
	assign reg_write_out = wr_r;
	assign acc_out = acc_r;
	assign flags_out = flags_r;
	assign osc_halt_out = halt_r;
	assign done_out = done_r;
endmodule : rotate_sub_swap_test_sleep_exec
`default_nettype wire

// [tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic clock_in=0;
	logic sys_rst_in=1;
	logic instr_valid_in=0;
	logic wake_in=0;
	logic [13:0] instr_in=0;
	logic [7:0] reg_rdata_in=0;
	exec_pkg::reg_write_t reg_write_out;
	exec_pkg::flags_t flags_out;
	logic [7:0] acc_out;
	logic osc_halt_out;
	logic done_out;
	int n_errors=0;
	int compares=0;
	rotate_sub_swap_test_sleep_exec u_dut(.*,.reg_raddr_out());
	always #2 clock_in=~clock_in;
	task wrap_up;
		$display("%0d errors, %0d compares",n_errors,compares);
		if(n_errors==0&&compares>0)$display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	task chk(input logic [30:0] s,input logic [30:0] e);
		compares++;
		if(s!==e)begin
			n_errors++;
			$display("mismatch %0t got %h want %h",$time,s,e);
		end
	endtask : chk
	// e packs done, halt, write {en,addr,data}, acc, flags
	task step(input logic [13:0] w,input logic [7:0] v,input logic [30:0] e);
		instr_in=w;
		reg_rdata_in=v;
		instr_valid_in=1;
		@(negedge clock_in);
		instr_valid_in=0;
		reg_rdata_in=~v;
		chk({done_out,osc_halt_out,reg_write_out.en?reg_write_out:16'h0,acc_out,flags_out},e);
		// idle cycle checks that done and the write enable drop back to 0 after one cycle
		@(negedge clock_in);
		chk({done_out,reg_write_out.en},31'h0);
	endtask : step
	task t_halt;
		step(14'h0d80,8'hff,31'h20000017);
		wake_in=1;
		repeat(3)@(negedge clock_in);
		wake_in=0;
		chk(osc_halt_out,31'h0);
		step(14'h0d80,8'h80,31'h50002017);
		$display("halt and wake end");
	endtask : t_halt
	task t_rot;
		step(14'h0d85,8'he6,31'h50b98019);
		step(14'h0d7f,8'h00,31'h40000038);
		$display("rotate end");
	endtask : t_rot
	task t_sub;
		step(14'h0e00,8'h2a,31'h40001458);
		step(14'h0280,8'h01,31'h500bf458);
		step(14'h0200,8'ha2,31'h4000001f);
		$display("subtract end");
	endtask : t_sub
	task t_zs;
		step(14'h08c0,8'h40,31'h4000001b);
		step(14'h08c0,8'h00,31'h4000001f);
		step(14'h0003,8'h00,31'h60000017);
		$display("zero test and sleep end");
	endtask : t_zs
	initial begin
		repeat(300)@(posedge clock_in);
		n_errors++;
		wrap_up;
	end
	initial begin
		repeat(10)@(negedge clock_in);
		sys_rst_in=0;
		@(negedge clock_in);
		t_rot;
		t_sub;
		t_zs;
		t_halt;
		wrap_up;
	end
endmodule : tb
`default_nettype wire
